// File: core/mapb_top.sv
// Motion parameter bank: APB byte store and the logic that uses it.
// Overview of operation
// - Locations undefined until host runs engine_initialisation
// - Byte-wide read/write locations on main clock
// - 32-bit parameters little-endian over four bytes
// - Step counts when magnitude exceeds amplitude threshold
// - Gait energy above threshold means running
// - Sensitivity setting is 0 or 1, default 0
// - Significant motion value shifts low-variance threshold
// - Mounting bits: swap, flip X, flip Y
// - Hysteresis added/removed around norm estimate
// - Absolute viewing X must stay within tilt limit
// - Slow-walk threshold used only when sensitivity is 1
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
module mapb_top #(
    parameter int AXIS_W = 16
) (
    // Clock and reset
    input  wire logic                     sys_clk_i,
    input  wire logic                     sys_rst_i,
    // APB slave
    input  wire logic                     psel_i,
    input  wire logic                     penable_i,
    input  wire logic                     pwrite_i,
    input  wire logic [12:0]              paddr_i,
    input  wire logic [31:0]              pwdata_i,
    input  wire logic [3:0]               pstrb_i,
    output logic [31:0]                   prdata_o,
    output logic                          pready_o,
    output logic                          pslverr_o,
    // Step counter inputs
    input  wire logic [31:0]              abs_accel_i,
    input  wire logic [31:0]              gait_energy_i,
    input  wire logic [31:0]              slow_walk_amplitude_threshold_i,
    // Significant motion input
    input  wire logic [31:0]              mot_base_threshold_i,
    // Gesture inputs
    input  wire logic [31:0]              norm_estimate_i,
    input  wire logic signed [AXIS_W-1:0] raw_x_i,
    input  wire logic signed [AXIS_W-1:0] raw_y_i,
    // Parameter-driven results
    output logic                          params_valid_o,
    output logic                          slow_walk_mode_o,
    output logic                          step_valid_o,
    output logic                          running_o,
    output logic [31:0]                   mot_threshold_o,
    output logic [31:0]                   norm_upper_o,
    output logic [31:0]                   norm_lower_o,
    output logic                          tilt_ok_o,
    output logic signed [AXIS_W-1:0]      axis_x_o,
    output logic signed [AXIS_W-1:0]      axis_y_o
);

    // ****************************************************************
    // Address decode
    // ****************************************************************
    typedef struct packed {
        logic       hit;
        logic [4:0] slot;
    } mapb_slot_t;

    function automatic mapb_slot_t mapb_find_slot(input logic [10:0] idx);
        mapb_slot_t res;
        res.hit  = 1'b0;
        res.slot = '0;
        for (int k = 0; k < mapb_pkg::NUM_SLOTS; k++) begin
            if (mapb_pkg::SLOT_INDEX[k] == idx) begin
                res.hit  = 1'b1;
                res.slot = 5'(k);
            end
        end
        return res;
    endfunction

    wire logic [10:0] acc_idx;
    wire logic        acc_aligned;
    wire mapb_slot_t  acc_slot;
    wire logic        acc_ctrl;
    wire logic        acc_ok;
    wire logic        setup_ph;
    wire logic        access_ph;
    wire logic        wr_byte;
    wire logic        wr_ctrl;

    assign acc_idx     = paddr_i[12:mapb_pkg::WORD_LSB];
    assign acc_aligned = (paddr_i[mapb_pkg::WORD_LSB-1:0] == 2'h0);
    assign acc_slot    = mapb_find_slot(acc_idx);
    assign acc_ctrl    = (acc_idx == mapb_pkg::IDX_CTRL);
    assign acc_ok      = acc_aligned && (acc_slot.hit || acc_ctrl);
    assign setup_ph    = psel_i && !penable_i;
    assign access_ph   = psel_i && penable_i;
    assign wr_byte     = access_ph && pwrite_i && acc_aligned && acc_slot.hit && pstrb_i[0];
    assign wr_ctrl     = access_ph && pwrite_i && acc_aligned && acc_ctrl && pstrb_i[0];

    // Zero wait states; read data was captured in the setup cycle
    assign pready_o    = 1'b1;
    assign pslverr_o   = access_ph && !acc_ok;

    // ****************************************************************
    // Parameter store
    // ****************************************************************
    // No reset on purpose: content is unknown until the host loads it
    logic [7:0] mem [mapb_pkg::NUM_SLOTS];

    always_ff @(posedge sys_clk_i) begin
        if (wr_byte) begin
            mem[acc_slot.slot] <= pwdata_i[7:0];
        end
    end

    // Host marks the store loaded; cleared again by writing zero
    logic valid_reg;
    wire  logic valid_next;

    assign valid_next = wr_ctrl ? pwdata_i[mapb_pkg::CTRL_VALID] : valid_reg;

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            valid_reg <= 1'b0;
        end else begin
            valid_reg <= valid_next;
        end
    end

    // ****************************************************************
    // Register read path
    // ****************************************************************
    logic [31:0] rdata_reg;
    wire  logic [31:0] rdata_next;
    wire  logic [31:0] ctrl_view;
    wire  logic [31:0] byte_view;
    wire  logic        slow_mode;

    assign ctrl_view  = {30'h0, slow_mode, valid_reg};
    assign byte_view  = {24'h0, mem[acc_slot.slot]};
    assign rdata_next = !acc_aligned  ? 32'h0 :
                        acc_ctrl      ? ctrl_view :
                        acc_slot.hit  ? byte_view : 32'h0;

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_reg <= 32'h0;
        end else if (setup_ph && !pwrite_i) begin
            rdata_reg <= rdata_next;
        end
    end

    assign prdata_o = rdata_reg;

    // ****************************************************************
    // Word assembly
    // ****************************************************************
    function automatic logic [31:0] mapb_word(input int base);
        return {mem[base+3], mem[base+2], mem[base+1], mem[base]};
    endfunction

    logic      [31:0] amp_thr;
    logic      [31:0] wr_thr;
    logic      [31:0] hys_val;
    logic      [31:0] tlt_lim;
    wire logic [7:0]  sens_val;
    wire logic [7:0]  mot_val;
    wire logic [2:0]  mount_val;

    // Process form, so every byte write re-evaluates the words
    always_comb begin
        amp_thr = mapb_word(mapb_pkg::SLOT_AMP);
        wr_thr  = mapb_word(mapb_pkg::SLOT_WR);
        hys_val = mapb_word(mapb_pkg::SLOT_HYS);
        tlt_lim = mapb_word(mapb_pkg::SLOT_TLT);
    end
    assign sens_val  = mem[mapb_pkg::SLOT_SENS];
    assign mot_val   = mem[mapb_pkg::SLOT_MOT];
    assign mount_val = mem[mapb_pkg::SLOT_MOUNT][2:0];

    // ****************************************************************
    // Step counter decisions
    // ****************************************************************
    wire logic [31:0] active_amp_thr;
    wire logic        step_next;
    wire logic        run_next;

    // Only exactly 1 selects slow walk; anything else acts as 0
    assign slow_mode      = valid_reg && (sens_val == mapb_pkg::SENS_SLOW);
    assign active_amp_thr = slow_mode ? slow_walk_amplitude_threshold_i : amp_thr;
    assign step_next      = valid_reg && (abs_accel_i > active_amp_thr);
    assign run_next       = valid_reg && (gait_energy_i > wr_thr);

    // ****************************************************************
    // Significant motion threshold
    // ****************************************************************
    wire logic [2:0]  mot_shift;
    wire logic [31:0] mot_next;

    // Values past the top of the range saturate
    assign mot_shift = (mot_val > 8'(mapb_pkg::MOT_SHIFT_MAX)) ?
                       mapb_pkg::MOT_SHIFT_MAX : mot_val[2:0];
    assign mot_next  = valid_reg ? (mot_base_threshold_i >> mot_shift) : 32'h0;

    // ****************************************************************
    // Gesture hysteresis and tilt
    // ****************************************************************
    wire logic signed [AXIS_W-1:0] mnt_x;
    wire logic signed [AXIS_W-1:0] mnt_y;
    wire logic [AXIS_W:0]          abs_x;
    wire logic [31:0]              up_next;
    wire logic [31:0]              lo_next;
    wire logic                     tilt_next;

    mapb_axis_mount #(
        .AXIS_W   (AXIS_W)
    ) u_axis_mount (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .mount_i   (mount_val),
        .raw_x_i   (raw_x_i),
        .raw_y_i   (raw_y_i),
        .mnt_x_o   (mnt_x),
        .mnt_y_o   (mnt_y)
    );

    assign up_next   = valid_reg ? 32'(norm_estimate_i + hys_val) : 32'h0;
    assign lo_next   = valid_reg ? 32'(norm_estimate_i - hys_val) : 32'h0;
    assign abs_x     = mnt_x[AXIS_W-1] ? (AXIS_W+1)'(-mnt_x) : (AXIS_W+1)'(mnt_x);
    assign tilt_next = valid_reg && (32'(abs_x) <= tlt_lim);

    // ****************************************************************
    // Output registers
    // ****************************************************************
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            step_valid_o    <= 1'b0;
            running_o       <= 1'b0;
            mot_threshold_o <= 32'h0;
            norm_upper_o    <= 32'h0;
            norm_lower_o    <= 32'h0;
            tilt_ok_o       <= 1'b0;
            axis_x_o        <= '0;
            axis_y_o        <= '0;
            slow_walk_mode_o <= 1'b0;
        end else begin
            step_valid_o    <= step_next;
            running_o       <= run_next;
            mot_threshold_o <= mot_next;
            norm_upper_o    <= up_next;
            norm_lower_o    <= lo_next;
            tilt_ok_o       <= tilt_next;
            axis_x_o        <= valid_reg ? mnt_x : '0;
            axis_y_o        <= valid_reg ? mnt_y : '0;
            slow_walk_mode_o <= slow_mode;
        end
    end

    assign params_valid_o = valid_reg;

endmodule // mapb_top

// File: pkg/mapb_pkg.sv
// Constants for the motion parameter bank: map, fields, defaults.
package mapb_pkg;

    // ****************************************************************
    // Geometry
    // ****************************************************************
    localparam int          NUM_SLOTS   = 19;
    localparam int          IDX_W       = 11;
    localparam int          BYTE_W      = 8;
    localparam int          PARAM_W     = 32;
    localparam int          APB_AW      = 13;
    localparam int          APB_DW      = 32;
    localparam int          WORD_LSB    = 2;

    // ****************************************************************
    // Location indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [10:0] IDX_AMP_B0  = 11'h388;
    localparam logic [10:0] IDX_AMP_B1  = 11'h389;
    localparam logic [10:0] IDX_AMP_B2  = 11'h38A;
    localparam logic [10:0] IDX_AMP_B3  = 11'h38B;
    localparam logic [10:0] IDX_WR_B0   = 11'h38C;
    localparam logic [10:0] IDX_WR_B1   = 11'h38D;
    localparam logic [10:0] IDX_WR_B2   = 11'h38E;
    localparam logic [10:0] IDX_WR_B3   = 11'h38F;
    localparam logic [10:0] IDX_SENS    = 11'h390;
    localparam logic [10:0] IDX_MOT     = 11'h3AA;
    localparam logic [10:0] IDX_MOUNT   = 11'h42C;
    localparam logic [10:0] IDX_HYS_B0  = 11'h430;
    localparam logic [10:0] IDX_HYS_B1  = 11'h431;
    localparam logic [10:0] IDX_HYS_B2  = 11'h432;
    localparam logic [10:0] IDX_HYS_B3  = 11'h433;
    localparam logic [10:0] IDX_TLT_B0  = 11'h434;
    localparam logic [10:0] IDX_TLT_B1  = 11'h435;
    localparam logic [10:0] IDX_TLT_B2  = 11'h436;
    localparam logic [10:0] IDX_TLT_B3  = 11'h437;
    localparam logic [10:0] IDX_CTRL    = 11'h3F8;

    // Slot order inside the byte array
    localparam logic [10:0] SLOT_INDEX [NUM_SLOTS] = '{
        IDX_AMP_B0, IDX_AMP_B1, IDX_AMP_B2, IDX_AMP_B3,
        IDX_WR_B0,  IDX_WR_B1,  IDX_WR_B2,  IDX_WR_B3,
        IDX_SENS,   IDX_MOT,    IDX_MOUNT,
        IDX_HYS_B0, IDX_HYS_B1, IDX_HYS_B2, IDX_HYS_B3,
        IDX_TLT_B0, IDX_TLT_B1, IDX_TLT_B2, IDX_TLT_B3
    };
    localparam int          SLOT_AMP    = 0;
    localparam int          SLOT_WR     = 4;
    localparam int          SLOT_SENS   = 8;
    localparam int          SLOT_MOT    = 9;
    localparam int          SLOT_MOUNT  = 10;
    localparam int          SLOT_HYS    = 11;
    localparam int          SLOT_TLT    = 15;

    // ****************************************************************
    // Fields
    // ****************************************************************
    localparam int          MOUNT_SWAP  = 2;
    localparam int          MOUNT_FLIPX = 1;
    localparam int          MOUNT_FLIPY = 0;
    localparam int          CTRL_VALID  = 0;
    localparam int          CTRL_SLOW   = 1;
    localparam logic [7:0]  SENS_SLOW   = 8'h01;
    localparam logic [2:0]  MOT_SHIFT_MAX = 3'h4;

    // ****************************************************************
    // Host defaults and recommended ranges
    // ****************************************************************
    localparam logic [31:0] AMP_DEFAULT = 32'd2080374;
    localparam logic [31:0] AMP_MIN     = 32'd1006632;
    localparam logic [31:0] AMP_MAX     = 32'd3019898;
    localparam logic [31:0] WR_DEFAULT  = 32'd3506176;
    localparam logic [31:0] WR_MIN      = 32'd2949120;
    localparam logic [31:0] WR_MAX      = 32'd5210112;
    localparam logic [7:0]  SENS_DEFAULT = 8'h00;
    localparam logic [7:0]  MOT_DEFAULT = 8'h00;
    localparam logic [31:0] HYS_DEFAULT = 32'd700;
    localparam logic [31:0] HYS_MIN     = 32'd1;
    localparam logic [31:0] HYS_MAX     = 32'd2048;
    localparam logic [31:0] TLT_DEFAULT = 32'd2048;
    localparam logic [31:0] TLT_MIN     = 32'd300;
    localparam logic [31:0] TLT_MAX     = 32'd3000;

endpackage

// File: core/mapb_axis_mount.sv
// Axis remapping for the gesture path: swap then sign flips.
`timescale 1ns/1ps
module mapb_axis_mount #(
    parameter int AXIS_W = 16
) (
    // Clock and reset
    input  wire logic                     sys_clk_i,
    input  wire logic                     sys_rst_i,
    // Mounting code and raw axes
    input  wire logic [2:0]               mount_i,
    input  wire logic signed [AXIS_W-1:0] raw_x_i,
    input  wire logic signed [AXIS_W-1:0] raw_y_i,
    // Remapped axes
    output logic signed [AXIS_W-1:0]      mnt_x_o,
    output logic signed [AXIS_W-1:0]      mnt_y_o
);

    wire logic signed [AXIS_W-1:0] sw_x;
    wire logic signed [AXIS_W-1:0] sw_y;
    wire logic signed [AXIS_W-1:0] x_next;
    wire logic signed [AXIS_W-1:0] y_next;

    assign sw_x   = mount_i[mapb_pkg::MOUNT_SWAP]  ? raw_y_i : raw_x_i;
    assign sw_y   = mount_i[mapb_pkg::MOUNT_SWAP]  ? raw_x_i : raw_y_i;
    assign x_next = mount_i[mapb_pkg::MOUNT_FLIPX] ? -sw_x : sw_x;
    assign y_next = mount_i[mapb_pkg::MOUNT_FLIPY] ? -sw_y : sw_y;

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mnt_x_o <= '0;
            mnt_y_o <= '0;
        end else begin
            mnt_x_o <= x_next;
            mnt_y_o <= y_next;
        end
    end

endmodule // mapb_axis_mount

// File: dv/mapb_props.sv
// Checker on the parameter bank top-level ports.
`timescale 1ns/1ps
module mapb_props #(
    parameter int AXIS_W = 16
) (
    // Clock, reset and bus
    input wire logic                     sys_clk_i,
    input wire logic                     sys_rst_i,
    input wire logic                     psel_i,
    input wire logic                     penable_i,
    input wire logic                     pwrite_i,
    input wire logic [12:0]              paddr_i,
    input wire logic [31:0]              prdata_o,
    input wire logic                     pready_o,
    input wire logic                     pslverr_o,
    // Processing path
    input wire logic [31:0]              mot_base_threshold_i,
    input wire logic [31:0]              norm_estimate_i,
    input wire logic signed [AXIS_W-1:0] raw_x_i,
    input wire logic signed [AXIS_W-1:0] raw_y_i,
    input wire logic                     params_valid_o,
    input wire logic                     slow_walk_mode_o,
    input wire logic                     step_valid_o,
    input wire logic                     running_o,
    input wire logic [31:0]              mot_threshold_o,
    input wire logic [31:0]              norm_upper_o,
    input wire logic [31:0]              norm_lower_o,
    input wire logic                     tilt_ok_o,
    input wire logic signed [AXIS_W-1:0] axis_x_o,
    input wire logic signed [AXIS_W-1:0] axis_y_o
);
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    function automatic logic [AXIS_W:0] mag(input logic signed [AXIS_W-1:0] v);
        return v[AXIS_W-1] ? -{v[AXIS_W-1], v} : {1'b0, v};
    endfunction

    sequence s_bad_setup;
        psel_i && !penable_i && paddr_i[1:0] != 2'h0;
    endsequence
    sequence s_access;
        psel_i && penable_i;
    endsequence

    property p_ready;
        pready_o == 1'b1;
    endproperty
    property p_bad_err;
        s_bad_setup ##1 s_access |-> pslverr_o && (pwrite_i || prdata_o == 32'h0);
    endproperty
    property p_err_access;
        pslverr_o |-> psel_i && penable_i;
    endproperty
    property p_idle_quiet;
        !params_valid_o |=> !step_valid_o && !running_o && mot_threshold_o == 32'h0;
    endproperty
    property p_norm_span;
        $past(params_valid_o) && params_valid_o |->
            norm_upper_o - $past(norm_estimate_i) == $past(norm_estimate_i) - norm_lower_o;
    endproperty
    property p_axis_perm;
        $past(params_valid_o, 2) && $past(params_valid_o) && params_valid_o |->
            (mag(axis_x_o) == mag($past(raw_x_i, 2)) && mag(axis_y_o) == mag($past(raw_y_i, 2)))
            || (mag(axis_x_o) == mag($past(raw_y_i, 2)) && mag(axis_y_o) == mag($past(raw_x_i, 2)));
    endproperty
    property p_slow_valid;
        slow_walk_mode_o |-> $past(params_valid_o);
    endproperty
    property p_mot_bound;
        $past(params_valid_o) && params_valid_o |->
            mot_threshold_o <= $past(mot_base_threshold_i)
            && mot_threshold_o >= ($past(mot_base_threshold_i) >> 4);
    endproperty

    a_ready: assert property (p_ready) else $error("bus ready dropped");
    a_bad_err: assert property (p_bad_err) else $error("misaligned access not refused");
    a_err_access: assert property (p_err_access) else $error("error outside access");
    a_idle_quiet: assert property (p_idle_quiet) else $error("output active before init");
    a_norm_span: assert property (p_norm_span) else $error("norm band not symmetric");
    a_axis_perm: assert property (p_axis_perm) else $error("axis magnitudes altered");
    a_slow_valid: assert property (p_slow_valid) else $error("slow walk without init");
    a_mot_bound: assert property (p_mot_bound) else $error("motion shift out of range");
endmodule // mapb_props

bind mapb_top mapb_props #(.AXIS_W(AXIS_W)) u_props (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .mot_base_threshold_i(mot_base_threshold_i),
    .norm_estimate_i(norm_estimate_i), .raw_x_i(raw_x_i), .raw_y_i(raw_y_i),
    .params_valid_o(params_valid_o), .slow_walk_mode_o(slow_walk_mode_o),
    .step_valid_o(step_valid_o), .running_o(running_o), .mot_threshold_o(mot_threshold_o),
    .norm_upper_o(norm_upper_o), .norm_lower_o(norm_lower_o), .tilt_ok_o(tilt_ok_o),
    .axis_x_o(axis_x_o), .axis_y_o(axis_y_o));

// File: dv/mapb_host.sv
// Host processor model issuing bus transfers to the parameter bank.
`timescale 1ns/1ps
module mapb_host (
    // Clock
    input  wire logic        sys_clk_i,
    // Bus master side
    output logic             psel_o,
    output logic             penable_o,
    output logic             pwrite_o,
    output logic [12:0]      paddr_o,
    output logic [31:0]      pwdata_o,
    output logic [3:0]       pstrb_o,
    input  wire logic [31:0] prdata_i,
    input  wire logic        pready_i,
    input  wire logic        pslverr_i
);
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 13'h0000;
        pwdata_o = 32'h0000_0000;
        pstrb_o = 4'h0;
    end

    // One transfer, request held until ready is seen high
    task automatic xfer(input logic wr, input logic [12:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [31:0] rd, output logic err);
        @(posedge sys_clk_i);
        psel_o <= 1'b1;
        penable_o <= 1'b0;
        pwrite_o <= wr;
        paddr_o <= a;
        pwdata_o <= d;
        pstrb_o <= s;
        @(posedge sys_clk_i);
        penable_o <= 1'b1;
        @(posedge sys_clk_i);
        while (pready_i !== 1'b1) @(posedge sys_clk_i);
        rd = prdata_i;
        err = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
    endtask
endmodule // mapb_host

// File: dv/motion_algo_param_bank_tb.sv
// Self-checking bench of the parameter bank driven by the host model.
`timescale 1ns/1ps
module motion_algo_param_bank_tb;
    localparam int AW = 16;
    logic                 sys_clk_i = 1'b0;
    logic                 sys_rst_i = 1'b1;
    wire  [12:0]          paddr;
    wire  [31:0]          pwdata, prdata, mot_thr, n_up, n_lo;
    wire  [3:0]           pstrb;
    wire                  psel, penable, pwrite, pready, pslverr;
    wire                  pvalid, slow, step, run, tilt;
    wire  signed [AW-1:0] ax, ay;
    logic [31:0]          accel = '0, gait = '0, slow_thr = '0, mot_base = '0, norm = '0;
    logic signed [AW-1:0] rx = '0, ry = '0;
    logic [31:0]          seed = 32'h0000_0063;
    int                   num_errors = 0, checked = 0, cycles = 0;

    always #4 sys_clk_i = ~sys_clk_i;

    mapb_host u_host (.sys_clk_i(sys_clk_i), .psel_o(psel), .penable_o(penable),
        .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata), .pstrb_o(pstrb),
        .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr));
    mapb_top #(.AXIS_W(AW)) u_dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .abs_accel_i(accel), .gait_energy_i(gait),
        .slow_walk_amplitude_threshold_i(slow_thr), .mot_base_threshold_i(mot_base),
        .norm_estimate_i(norm), .raw_x_i(rx), .raw_y_i(ry), .params_valid_o(pvalid),
        .slow_walk_mode_o(slow), .step_valid_o(step), .running_o(run),
        .mot_threshold_o(mot_thr), .norm_upper_o(n_up), .norm_lower_o(n_lo),
        .tilt_ok_o(tilt), .axis_x_o(ax), .axis_y_o(ay));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] pick(input logic [31:0] lo, input logic [31:0] hi);
        return lo + rnd() % (hi - lo + 32'h1);
    endfunction
    // Expected {tilt, x, y} after mounting
    function automatic logic [2*AW:0] mnt(input logic [2:0] m, input logic signed [AW-1:0] x,
                                         input logic signed [AW-1:0] y, input logic [31:0] lim);
        logic signed [AW-1:0] a, b;
        logic [AW-1:0] ma;
        a = m[2] ? y : x;
        b = m[2] ? x : y;
        if (m[1]) a = -a;
        if (m[0]) b = -b;
        ma = a[AW-1] ? AW'(-a) : AW'(a);
        return {32'(ma) <= lim, a, b};
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic put(input logic [10:0] idx, input logic [31:0] v, input int n);
        logic [31:0] rd;
        logic e;
        for (int i = 0; i < n; i++) u_host.xfer(1'b1, {idx + 11'(i), 2'h0}, v >> (8 * i), 4'hF, rd, e);
    endtask
    task automatic get(input logic [10:0] idx, input logic [31:0] v, input int n);
        logic [31:0] rd;
        logic e;
        for (int i = 0; i < n; i++) begin
            u_host.xfer(1'b0, {idx + 11'(i), 2'h0}, 32'h0, 4'h0, rd, e);
            chk("stored byte", {24'h0, v[8*i +: 8]}, {24'h0, rd[7:0]});
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            complete_run();
        end
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        logic [31:0] amp, wr, hys, tl, act, rd;
        logic [7:0] sm, sens;
        logic [2:0] m;
        logic [2*AW:0] e;
        logic err;
        repeat (16) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        accel <= 32'hFFFF_FFFF;
        gait <= 32'hFFFF_FFFF;
        mot_base <= 32'hFFFF_FFFF;
        repeat (3) @(posedge sys_clk_i);
        #1;
        chk("step before init", 32'h0, {31'h0, step});
        chk("shift before init", 32'h0, mot_thr);
        u_host.xfer(1'b0, {mapb_pkg::IDX_AMP_B0, 2'h1}, 32'h0, 4'h0, rd, err);
        chk("misaligned read", 32'h0, rd | {31'h0, ~err});
        u_host.xfer(1'b0, 13'h0000, 32'h0, 4'h0, rd, err);
        chk("unmapped error", 32'h1, {31'h0, err});
        put(mapb_pkg::IDX_SENS, 32'h0, 1);
        u_host.xfer(1'b1, {mapb_pkg::IDX_SENS, 2'h0}, 32'h1, 4'h0, rd, err);
        get(mapb_pkg::IDX_SENS, 32'h0, 1);
        for (int k = 0; k < 24; k++) begin
            amp = k == 0 ? mapb_pkg::AMP_DEFAULT : pick(mapb_pkg::AMP_MIN, mapb_pkg::AMP_MAX);
            wr = k == 0 ? mapb_pkg::WR_DEFAULT : pick(mapb_pkg::WR_MIN, mapb_pkg::WR_MAX);
            hys = k == 0 ? mapb_pkg::HYS_DEFAULT : pick(mapb_pkg::HYS_MIN, mapb_pkg::HYS_MAX);
            tl = k == 0 ? mapb_pkg::TLT_DEFAULT : pick(mapb_pkg::TLT_MIN, mapb_pkg::TLT_MAX);
            sm = 8'(pick(32'h0, 32'h4));
            sens = 8'(k % 2);
            m = 3'(k);
            put(mapb_pkg::IDX_AMP_B0, amp, 4);
            put(mapb_pkg::IDX_WR_B0, wr, 4);
            put(mapb_pkg::IDX_SENS, {24'h0, sens}, 1);
            put(mapb_pkg::IDX_MOT, {24'h0, sm}, 1);
            put(mapb_pkg::IDX_MOUNT, {29'h0, m}, 1);
            put(mapb_pkg::IDX_HYS_B0, hys, 4);
            put(mapb_pkg::IDX_TLT_B0, tl, 4);
            if (k == 0) put(mapb_pkg::IDX_CTRL, 32'h1, 1);
            get(mapb_pkg::IDX_AMP_B0, amp, 4);
            rd = rnd();
            slow_thr <= rd;
            act = sens == 8'h01 ? rd : amp;
            accel <= act + rnd() % 3 - 32'h1;
            gait <= wr + rnd() % 3 - 32'h1;
            mot_base <= rnd();
            norm <= rnd();
            rx <= AW'(rnd());
            ry <= AW'(rnd());
            repeat (3) @(posedge sys_clk_i);
            #1;
            e = mnt(m, rx, ry, tl);
            chk("slow mode", {31'h0, sens == 8'h01}, {31'h0, slow});
            chk("step", {31'h0, accel > act}, {31'h0, step});
            chk("running", {31'h0, gait > wr}, {31'h0, run});
            chk("motion threshold", mot_base >> sm, mot_thr);
            chk("norm upper", norm + hys, n_up);
            chk("norm lower", norm - hys, n_lo);
            chk("axis", {e[2*AW-1:0]}, {ax, ay});
            chk("tilt", {31'h0, e[2*AW]}, {31'h0, tilt});
            chk("valid", 32'h1, {31'h0, pvalid});
        end
        put(mapb_pkg::IDX_CTRL, 32'h0, 1);
        repeat (3) @(posedge sys_clk_i);
        #1;
        chk("step after clear", 32'h0, {31'h0, step | run | pvalid});
        complete_run();
    end
endmodule // motion_algo_param_bank_tb
